// file: logic/srw_pkg.sv
// Constants shared by the reset supervisor and its input filter
package srw_pkg;

    // ========================================================
    // Time base
    // ========================================================
    localparam int unsigned CLK_HZ         = 100_000_000;
    localparam int unsigned CLK_PER_MS     = CLK_HZ / 1000;
    localparam int unsigned CLK_MHZ        = CLK_HZ / 1_000_000;

    // ========================================================
    // Reset stretch, nominal 200 ms
    // ========================================================
    localparam int unsigned RST_TIMEOUT_MS  = 200;
    localparam int unsigned RST_TIMEOUT_CYC = RST_TIMEOUT_MS * CLK_PER_MS;

    // ========================================================
    // Watchdog timeout, typical 1.6 s
    // ========================================================
    localparam int unsigned WD_TIMEOUT_MS  = 1600;
    localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CLK_PER_MS;

    // ========================================================
    // Manual request glitch rejection, 100 ns, rounded up
    // ========================================================
    localparam int unsigned MR_REJECT_NS  = 100;
    localparam int unsigned MR_REJECT_CYC = (MR_REJECT_NS * CLK_MHZ + 999) / 1000;

    // ========================================================
    // Counter widths
    // ========================================================
    localparam int unsigned TMR_W  = 32;
    localparam int unsigned FILT_W = 8;

    // ========================================================
    // Synchroniser lanes
    // ========================================================
    localparam int unsigned SYNC_N     = 4;
    localparam int unsigned LANE_SUPPLY = 0;
    localparam int unsigned LANE_MR     = 1;
    localparam int unsigned LANE_KICK   = 2;
    localparam int unsigned LANE_DRIVEN = 3;
    localparam logic [SYNC_N-1:0] SYNC_RST = 4'h2;

    // ========================================================
    // Sequencer states
    // ========================================================
    typedef enum logic [1:0] {
        ST_HOLD    = 2'b00,
        ST_STRETCH = 2'b01,
        ST_RUN     = 2'b10
    } srw_state_t;

endpackage

// file: logic/srw_glitch_filter.sv
// Low-pulse rejection filter for the manual request input
`timescale 1ns/1ps
module srw_glitch_filter
    import srw_pkg::*;
#(
    parameter int unsigned REJECT_CYC = MR_REJECT_CYC
)
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,
    // Synchronised active-low level
    input  wire logic level_n_i,
    // Filtered low indication
    output logic      low_o
);

    logic [FILT_W-1:0] cnt_ff;
    logic [FILT_W-1:0] nxt_cnt;
    logic              low_ff;
    logic              nxt_low;

    // ========================================================
    // Low must persist for the full count before it is accepted
    // ========================================================
    always_comb
    begin
        nxt_cnt = cnt_ff;
        nxt_low = low_ff;
        if (level_n_i)
        begin
            // Release is immediate; only assertion is filtered
            nxt_cnt = '0;
            nxt_low = 1'b0;
        end
        else if (cnt_ff >= FILT_W'(REJECT_CYC - 1))
        begin
            nxt_low = 1'b1;
        end
        else
        begin
            nxt_cnt = cnt_ff + FILT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_ff <= '0;
            low_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            low_ff <= nxt_low;
        end
    end

    assign low_o = low_ff;

endmodule

// file: logic/srw_supervisor.sv
// Reset supervisor: supply, manual request and watchdog to reset pair
//
// Function
// - any source gives a 200 ms reset pulse
// - reset held 200 ms after source clears
// - active-high reset is complement of active-low
// - steady kick past timeout triggers reset
// - watchdog cleared by reset and kick edges
// - undriven kick line disables the watchdog
// - manual request low holds reset asserted
// - manual low pulses under 100 ns ignored
// - supply low asserts reset via the synchroniser, unfiltered
// - full timeout after supply recovers
// - watchdog counts only while reset released
`timescale 1ns/1ps
module srw_supervisor
    import srw_pkg::*;
#(
    parameter int unsigned RST_CYC    = RST_TIMEOUT_CYC,
    parameter int unsigned WD_CYC     = WD_TIMEOUT_CYC,
    parameter int unsigned REJECT_CYC = MR_REJECT_CYC
)
(
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_i,

    // Reset sources
    input  wire logic supply_low_i,
    input  wire logic manual_request_n_i,

    // Watchdog
    input  wire logic watchdog_kick_in_i,
    input  wire logic watchdog_kick_driven_i,

    // Reset pair
    output logic      reset_n_o,
    output logic      reset_o
);

    // ========================================================
    // Declarations
    // ========================================================
    logic [SYNC_N-1:0] sync1_ff;
    logic [SYNC_N-1:0] sync2_ff;
    logic [SYNC_N-1:0] nxt_sync1;
    logic [SYNC_N-1:0] nxt_sync2;

    logic              kick_prev_ff;
    logic              nxt_kick_prev;

    logic              supply_low_s;
    logic              mr_n_s;
    logic              kick_s;
    logic              kick_drv_s;

    logic              mr_low;
    logic              src_hold;
    logic              kick_edge;
    logic              wd_enabled;

    srw_state_t        state_ff;
    srw_state_t        nxt_state;
    logic [TMR_W-1:0]  stretch_ff;
    logic [TMR_W-1:0]  nxt_stretch;

    logic [TMR_W-1:0]  wd_cnt_ff;
    logic [TMR_W-1:0]  nxt_wd_cnt;
    logic              wd_expire;

    logic              reset_n_ff;
    logic              reset_ff;
    logic              nxt_reset_n;
    logic              nxt_reset;

    // ========================================================
    // Decoding shared by outputs and watchdog
    // ========================================================
    function automatic logic is_released(input srw_state_t st);
        is_released = (st == ST_RUN);
    endfunction

    // ========================================================
    // Pin synchronisers
    // ========================================================
    wire logic [SYNC_N-1:0] pins = {
        watchdog_kick_driven_i,
        watchdog_kick_in_i,
        manual_request_n_i,
        supply_low_i
    };

    // First stage feeds only the second stage
    genvar g;
    generate
        for (g = 0; g < SYNC_N; g++)
        begin : g_sync
            always_comb
            begin
                nxt_sync1[g] = pins[g];
                nxt_sync2[g] = sync1_ff[g];
            end
        end
    endgenerate

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync1_ff <= SYNC_RST;
            sync2_ff <= SYNC_RST;
        end
        else
        begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
        end
    end

    // ========================================================
    // Synchronised pin levels
    // ========================================================
    // Named taps keep the lane numbering in one place
    always_comb
    begin
        supply_low_s = sync2_ff[LANE_SUPPLY];
        mr_n_s       = sync2_ff[LANE_MR];
        kick_s       = sync2_ff[LANE_KICK];
        kick_drv_s   = sync2_ff[LANE_DRIVEN];
    end

    // ========================================================
    // Manual request filter
    // ========================================================
    // Reads the pin as released until the synchronised pin level is seen
    srw_glitch_filter #(
        .REJECT_CYC (REJECT_CYC)
    ) u_mr_filter (
        .clk_sys_i  (clk_sys_i),
        .rst_i      (rst_i),
        .level_n_i  (mr_n_s),
        .low_o      (mr_low)
    );

    // ========================================================
    // Source combination
    // ========================================================
    always_comb
    begin
        src_hold      = supply_low_s | mr_low;
        nxt_kick_prev = kick_s;
        kick_edge     = kick_s ^ kick_prev_ff;
        wd_enabled    = kick_drv_s;
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            kick_prev_ff <= 1'b0;
        end
        else
        begin
            kick_prev_ff <= nxt_kick_prev;
        end
    end

    // ========================================================
    // Watchdog timer
    // ========================================================
    always_comb
    begin
        nxt_wd_cnt = wd_cnt_ff;
        wd_expire  = 1'b0;
        // Undriven kick line parks the count, so a floating pin cannot fire it
        if (!is_released(state_ff) || kick_edge || !wd_enabled)
        begin
            // Restarts from zero on each release
            nxt_wd_cnt = '0;
        end
        else if (wd_cnt_ff >= TMR_W'(WD_CYC - 1))
        begin
            wd_expire  = 1'b1;
            nxt_wd_cnt = '0;
        end
        else
        begin
            nxt_wd_cnt = wd_cnt_ff + TMR_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wd_cnt_ff <= '0;
        end
        else
        begin
            wd_cnt_ff <= nxt_wd_cnt;
        end
    end

    // ========================================================
    // Reset sequencer
    // ========================================================
    // Power-up starts in the stretch so the load sees a full pulse
    always_comb
    begin
        nxt_state   = state_ff;
        nxt_stretch = stretch_ff;
        case (state_ff)
            ST_HOLD:
            begin
                nxt_stretch = '0;
                if (!src_hold)
                begin
                    nxt_state = ST_STRETCH;
                end
            end
            ST_STRETCH:
            begin
                // A source returning mid-stretch restarts the full timeout
                if (src_hold)
                begin
                    nxt_state   = ST_HOLD;
                    nxt_stretch = '0;
                end
                else if (stretch_ff >= TMR_W'(RST_CYC - 1))
                begin
                    nxt_state   = ST_RUN;
                    nxt_stretch = '0;
                end
                else
                begin
                    nxt_stretch = stretch_ff + TMR_W'(1);
                end
            end
            ST_RUN:
            begin
                nxt_stretch = '0;
                if (src_hold)
                begin
                    nxt_state = ST_HOLD;
                end
                else if (wd_expire)
                begin
                    nxt_state = ST_STRETCH;
                end
            end
            default:
            begin
                nxt_state   = ST_HOLD;
                nxt_stretch = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_ff   <= ST_STRETCH;
            stretch_ff <= '0;
        end
        else
        begin
            state_ff   <= nxt_state;
            stretch_ff <= nxt_stretch;
        end
    end

    // ========================================================
    // Output pair
    // ========================================================
    // Both taken from the next state so neither lags the other
    always_comb
    begin
        nxt_reset_n = is_released(nxt_state);
        nxt_reset   = ~is_released(nxt_state);
    end

    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            reset_n_ff <= 1'b0;
            reset_ff   <= 1'b1;
        end
        else
        begin
            reset_n_ff <= nxt_reset_n;
            reset_ff   <= nxt_reset;
        end
    end

    assign reset_n_o = reset_n_ff;
    assign reset_o   = reset_ff;

endmodule

// file: verification/srw_supervisor_chk.sv
// Port-level assertions for the reset supervisor
`timescale 1ns/1ps
module srw_supervisor_chk
    import srw_pkg::*;
#(
    parameter int unsigned RST_CYC = 50,
    parameter int unsigned WD_CYC  = 200
)
(
    // Watched ports
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic supply_low_i,
    input wire logic manual_request_n_i,
    input wire logic watchdog_kick_in_i,
    input wire logic watchdog_kick_driven_i,
    input wire logic reset_n_o,
    input wire logic reset_o
);
    // ========================================================
    // Run-length counters
    // ========================================================
    logic        src;
    logic        kick_ff;
    logic [31:0] low_ff, lowq_ff, stab_ff, nodrv_ff, quiet_ff;
    logic [31:0] nxt_low, nxt_lowq, nxt_stab, nxt_nodrv, nxt_quiet;
    assign src = supply_low_i | ~manual_request_n_i;
    always_comb
    begin
        nxt_low   = !reset_n_o ? low_ff + 32'h1 : 32'h0;
        nxt_lowq  = (!reset_n_o && !src) ? lowq_ff + 32'h1 : 32'h0;
        nxt_stab  = (reset_n_o && watchdog_kick_driven_i && watchdog_kick_in_i == kick_ff)
                    ? stab_ff + 32'h1 : 32'h0;
        nxt_nodrv = (!watchdog_kick_driven_i && !src) ? nodrv_ff + 32'h1 : 32'h0;
        nxt_quiet = !src ? quiet_ff + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            {low_ff, lowq_ff, stab_ff, nodrv_ff, quiet_ff} <= '0;
            kick_ff <= 1'b0;
        end
        else
        begin
            {low_ff, lowq_ff, stab_ff} <= {nxt_low, nxt_lowq, nxt_stab};
            {nodrv_ff, quiet_ff}       <= {nxt_nodrv, nxt_quiet};
            kick_ff <= watchdog_kick_in_i;
        end
    end
    // ========================================================
    // Properties
    // ========================================================
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence mr_low8;
        !manual_request_n_i [*8];
    endsequence
    pair_comp_a: assert property (reset_o == !reset_n_o)
        else $error("reset pair not complementary");
    supply_fast_a: assert property ($rose(supply_low_i) |-> ##[1:4] !reset_n_o)
        else $error("supply low did not assert reset");
    manual_hold_a: assert property (mr_low8 ##1 mr_low8 |-> !reset_n_o)
        else $error("manual request low without reset");
    stretch_min_a: assert property ($rose(reset_n_o) |-> $past(low_ff) >= RST_CYC - 2)
        else $error("reset pulse too short");
    stretch_max_a: assert property (lowq_ff <= RST_CYC + 6)
        else $error("reset held too long after sources cleared");
    wd_fire_a: assert property (stab_ff <= WD_CYC + 6)
        else $error("watchdog did not expire");
    wd_off_a: assert property ($fell(reset_n_o) |-> nodrv_ff < 8)
        else $error("reset with undriven kick line");
    wd_early_a: assert property ($fell(reset_n_o) && quiet_ff >= 8
        |-> $past(stab_ff) >= WD_CYC - 4)
        else $error("watchdog expired early");
endmodule

bind srw_supervisor srw_supervisor_chk #(.RST_CYC(RST_CYC), .WD_CYC(WD_CYC)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
    .manual_request_n_i(manual_request_n_i), .watchdog_kick_in_i(watchdog_kick_in_i),
    .watchdog_kick_driven_i(watchdog_kick_driven_i), .reset_n_o(reset_n_o),
    .reset_o(reset_o));

// file: verification/srw_host_model.sv
// Processor model that receives reset and strobes the watchdog
`timescale 1ns/1ps
module srw_host_model
#(
    parameter int unsigned KICK_GAP = 50
)
(
    // Clock and active-low reset
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    // Firmware state
    input  wire logic       kick_en_i,
    input  wire logic       drive_en_i,
    // Kick pin and reset entry count
    output logic            kick_o,
    output logic            driven_o,
    output logic [7:0]      resets_o
);
    int   gap;
    logic prev_n;
    logic drv_q;
    initial {kick_o, gap, prev_n, drv_q, resets_o} = '0;
    assign driven_o = drive_en_i;
    // Released line drifts once to the inverse of its last level
    always @(posedge clk_sys_i)
    begin
        prev_n <= reset_n_i;
        drv_q  <= drive_en_i;
        if (prev_n && !reset_n_i)
            resets_o <= resets_o + 8'h1;
        if (!drive_en_i && drv_q)
        begin
            kick_o <= ~kick_o;
            gap    <= 0;
        end
        else if (drive_en_i && gap == KICK_GAP - 1)
        begin
            kick_o <= ~kick_o;
            gap    <= 0;
        end
        else
            gap <= (reset_n_i && kick_en_i) ? gap + 1 : 0;
    end
endmodule

// file: verification/srw_supervisor_tb.sv
// Self-checking bench for the reset supervisor
`timescale 1ns/1ps
module srw_supervisor_tb;
    import srw_pkg::*;
    localparam int RST_CYC = 50;
    localparam int WD_CYC  = 200;
    logic       clk_sys_i, rst_i, supply_low_i, manual_request_n_i, kick_en, drive_en;
    logic       kick, driven, reset_n_o, reset_o;
    logic [7:0] resets, r0;
    int         err_count, n_compared, n;

    srw_supervisor #(.RST_CYC(RST_CYC), .WD_CYC(WD_CYC), .REJECT_CYC(10)) u_srw_supervisor (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .supply_low_i(supply_low_i),
        .manual_request_n_i(manual_request_n_i), .watchdog_kick_in_i(kick),
        .watchdog_kick_driven_i(driven), .reset_n_o(reset_n_o), .reset_o(reset_o));
    srw_host_model #(.KICK_GAP(50)) u_srw_host_model (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_o), .kick_en_i(kick_en),
        .drive_en_i(drive_en), .kick_o(kick), .driven_o(driven), .resets_o(resets));

    initial
    begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cyc(int c);
        repeat (c) @(posedge clk_sys_i);
    endtask
    // Cycles until reset_n_o reaches lvl; a hang ends the run
    task automatic wait_lvl(logic lvl, output int c);
        c = 0;
        while (reset_n_o !== lvl)
        begin
            @(posedge clk_sys_i);
            #1;
            c++;
            if (c > 1000)
            begin
                chk("wait bound", 0, 1);
                report_and_stop();
            end
        end
    endtask
    task automatic t_supply();
        @(posedge clk_sys_i) supply_low_i <= 1'b1;
        cyc(4);
        #1 chk("supply reset_n", reset_n_o, 0);
        chk("supply reset", reset_o, 1);
        cyc(100);
        supply_low_i <= 1'b0;
        wait_lvl(1'b1, n);
        chk("supply stretch", n >= RST_CYC + 1 && n <= RST_CYC + 5, 1);
    endtask
    task automatic t_manual();
        r0 = resets;
        @(posedge clk_sys_i) manual_request_n_i <= 1'b0;
        cyc(8);
        manual_request_n_i <= 1'b1;
        cyc(30);
        chk("glitch resets", resets, r0);
        manual_request_n_i <= 1'b0;
        cyc(100);
        #1 chk("manual held", reset_n_o, 0);
        @(posedge clk_sys_i) manual_request_n_i <= 1'b1;
        wait_lvl(1'b1, n);
        chk("manual stretch", n >= RST_CYC + 1 && n <= RST_CYC + 5, 1);
    endtask
    task automatic t_watchdog();
        @(posedge clk_sys_i) kick_en <= 1'b0;
        wait_lvl(1'b0, n);
        chk("wd expiry", n >= WD_CYC - 2 && n <= WD_CYC + 8, 1);
        wait_lvl(1'b1, n);
        chk("wd stretch", n >= RST_CYC - 2 && n <= RST_CYC + 3, 1);
        @(posedge clk_sys_i) kick_en <= 1'b1;
        r0 = resets;
        cyc(3 * WD_CYC);
        chk("kicked resets", resets, r0);
        drive_en <= 1'b0;
        cyc(3 * WD_CYC);
        chk("floating resets", resets, r0);
    endtask

    initial
    begin
        {err_count, n_compared} = '0;
        {supply_low_i, kick_en, drive_en} = 3'h3;
        manual_request_n_i = 1'b1;
        rst_i = 1'b1;
        cyc(10);
        rst_i <= 1'b0;
        #1 chk("por reset", reset_o, 1);
        wait_lvl(1'b1, n);
        chk("por stretch", n >= RST_CYC - 1 && n <= RST_CYC + 3, 1);
        t_supply();
        t_manual();
        t_watchdog();
        report_and_stop();
    end
endmodule
